// ### rtl/dwdt_counter.v
// Free-running period counter with clear, enable and one-cycle overflow pulse
`timescale 1ns/1ns
`default_nettype none

module dwdt_counter #(
    parameter WIDTH = 22
) (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_clear,
    input wire i_enable,
    input wire [WIDTH-1:0] i_limit,
    output reg [WIDTH-1:0] o_count,
    output reg o_overflow
);

    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_count <= {WIDTH{1'b0}};
            o_overflow <= 1'b0;
        end
        else
        begin
            o_overflow <= 1'b0;
            if (i_clear)
            begin
                o_count <= {WIDTH{1'b0}};
            end
            else if (i_enable)
            begin
                // >= so a shortened period still wraps at once
                if (o_count >= i_limit)
                begin
                    o_count <= {WIDTH{1'b0}};
                    o_overflow <= 1'b1;
                end
                else
                begin
                    o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### rtl/dwdt_defs.vh
// Register map, field positions, reset values and keys of the dual watchdog block
`ifndef DWDT_DEFS_VH
`define DWDT_DEFS_VH

// Byte offsets on the register bus
`define DWDT_OFS_WD1_MODE 5'h00
`define DWDT_OFS_WD1_PERIOD 5'h04
`define DWDT_OFS_WD1_IRQ_CTRL 5'h08
`define DWDT_OFS_WD2_MODE 5'h0C
`define DWDT_OFS_WD2_KEY 5'h10
`define DWDT_OFS_STATUS 5'h14

// watchdog1_mode fields
`define DWDT_WD1_RUN_BIT 7
`define DWDT_WD1_SEL_BIT 4
`define DWDT_WD1_ACT_BIT 3
`define DWDT_WD1_MODE_RST 2'h0

// wd1_period_select field
`define DWDT_WD1_PERIOD_MSB 2
`define DWDT_WD1_PERIOD_RST 3'h0
`define DWDT_WD1_SHIFT_BASE 5'h0D
`define DWDT_WD1_SHIFT_TOP 5'h15

// wd1_irq_control fields
`define DWDT_IC_FLAG_BIT 7
`define DWDT_IC_MASK_BIT 6
`define DWDT_IC_PRIO_MSB 2
`define DWDT_IC_MASK_RST 1'h1
`define DWDT_IC_PRIO_RST 3'h7

// watchdog2_mode fields
`define DWDT_WD2_MODE_RST 7'h67
`define DWDT_WD2_ACT_HI_BIT 6
`define DWDT_WD2_ACT_LO_BIT 5
`define DWDT_WD2_STOP_BIT 4
`define DWDT_WD2_SUB_BIT 3
`define DWDT_WD2_MAIN_BASE 5'h12
`define DWDT_WD2_SUB_BASE 5'h09

// watchdog2_refresh_key
`define DWDT_WD2_KEY_RST 8'h9A
`define DWDT_WD2_KEY_CLEAR 8'hAC

// Counter widths
`define DWDT_WD1_CW 22
`define DWDT_WD2_CW 26

`endif

// ### rtl/dwdt_top.v
// Dual program-loop watchdog timers with an Avalon-MM register slave
//
// Overview of operation
// - Run write clears counter, starts counting
// - Mode 01 overflow raises maskable interval interrupt
// - Mode 10 overflow raises timer one NMI
// - Mode 11 overflow starts timer one reset
// - Select bit set locks mode bits until reset
// - Three-bit field picks timer one period
// - Timer one halts in stop, idle; runs halt
// - Subclock CPU freezes timer one, holding count
// - Interval interrupt obeys mask and priority flags
// - Timer two runs after reset, mode 67H
// - Timer two mode takes one byte write
// - Written running timer two cannot be stopped
// - Five-bit field picks timer two period, source
// - Key ACH clears timer two, restarts count
// - Key register byte access, resets to 9AH
// - Timer two overflow gives reset or NMI
// - Main-clocked timer two stops in idle, stop
// - Timer two runs in halt, subclock standby
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "dwdt_defs.vh"

module dwdt_top (
    input wire i_clock,
    input wire i_sys_rst,
    input wire [4:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire i_idle_mode,
    input wire i_stop_mode,
    input wire i_cpu_subclock,
    input wire i_subclock_tick,
    output wire o_wd1_interval_irq,
    output wire [2:0] o_wd1_irq_priority,
    output reg o_wd1_nmi_request,
    output reg o_wd1_system_reset,
    output reg o_wd2_nmi_request,
    output reg o_wd2_system_reset
);

    // Bus handshake: one wait state per access
    reg bus_ack;
    wire bus_req;
    wire wr_go;
    wire wr_byte;
    wire [7:0] wr_data;

    // Timer one state
    reg wd1_run_clear_bit;
    reg wd1_watchdog_select;
    reg wd1_overflow_action;
    reg wd1_lock;
    reg [2:0] wd1_period_select;
    reg wd1_irq_flag;
    reg wd1_irq_mask;
    reg [2:0] wd1_irq_priority;

    // Timer two state
    reg wd2_written;
    reg [6:0] watchdog2_mode;
    reg [7:0] watchdog2_refresh_key;

    // Counter hookup
    wire wd1_clear;
    wire wd1_enable;
    wire [4:0] wd1_shift;
    wire [21:0] wd1_limit;
    wire wd1_overflow;
    wire wd2_clear;
    wire wd2_enable;
    wire wd2_running;
    wire [4:0] wd2_shift;
    wire [25:0] wd2_limit;
    wire wd2_overflow;
    wire [4:0] wd2_period_select;

    // Decoded writes
    wire wr_mode1;
    wire wr_period1;
    wire wr_ic;
    wire wr_mode2;
    wire wr_key;
    reg [7:0] next_readdata;

    assign bus_req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~bus_ack;
    assign wr_go = i_avs_write & bus_ack;
    assign wr_byte = wr_go & i_avs_byteenable[0];
    assign wr_data = i_avs_writedata[7:0];

    assign wr_mode1 = wr_byte & (i_avs_address == `DWDT_OFS_WD1_MODE);
    assign wr_period1 = wr_byte & (i_avs_address == `DWDT_OFS_WD1_PERIOD);
    assign wr_ic = wr_byte & (i_avs_address == `DWDT_OFS_WD1_IRQ_CTRL);
    assign wr_mode2 = wr_byte & (i_avs_address == `DWDT_OFS_WD2_MODE);
    assign wr_key = wr_byte & (i_avs_address == `DWDT_OFS_WD2_KEY);

    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            bus_ack <= 1'b0;
        end
        else
        begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // ---------------- Timer one ----------------

    assign wd1_clear = wr_mode1 & wr_data[`DWDT_WD1_RUN_BIT];
    // Stop, idle and a subclock-driven CPU freeze the count in place
    assign wd1_enable = wd1_run_clear_bit & ~i_idle_mode & ~i_stop_mode
        & ~i_cpu_subclock;

    // Code 7 jumps to the longest period rather than continuing the series
    assign wd1_shift = (wd1_period_select == 3'h7) ? `DWDT_WD1_SHIFT_TOP
        : (`DWDT_WD1_SHIFT_BASE + {2'h0, wd1_period_select});
    assign wd1_limit = (22'h000001 << wd1_shift) - 22'h000001;

    dwdt_counter #(
        .WIDTH(`DWDT_WD1_CW)
    ) u_wd1_counter (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clear(wd1_clear),
        .i_enable(wd1_enable),
        .i_limit(wd1_limit),
        // The count stays internal; software only sees what its wrap does
        .o_count(),
        .o_overflow(wd1_overflow)
    );

    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wd1_run_clear_bit <= 1'b0;
            wd1_watchdog_select <= 1'b0;
            wd1_overflow_action <= 1'b0;
            wd1_lock <= 1'b0;
            wd1_period_select <= `DWDT_WD1_PERIOD_RST;
        end
        else
        begin
            if (wd1_clear)
            begin
                // A zero in the run bit is ignored, so no write can stop the count
                wd1_run_clear_bit <= 1'b1;
            end
            if (wr_mode1 & ~wd1_lock)
            begin
                wd1_watchdog_select <= wr_data[`DWDT_WD1_SEL_BIT];
                wd1_overflow_action <= wr_data[`DWDT_WD1_ACT_BIT];
                wd1_lock <= wr_data[`DWDT_WD1_SEL_BIT];
            end
            if (wr_period1)
            begin
                wd1_period_select <= wr_data[`DWDT_WD1_PERIOD_MSB:0];
            end
        end
    end

    // Overflow actions, one-cycle pulses one clock after the wrap
    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_wd1_nmi_request <= 1'b0;
            o_wd1_system_reset <= 1'b0;
        end
        else
        begin
            o_wd1_nmi_request <= wd1_overflow & wd1_watchdog_select
                & ~wd1_overflow_action;
            o_wd1_system_reset <= wd1_overflow & wd1_watchdog_select
                & wd1_overflow_action;
        end
    end

    // Interrupt control: request flag, mask and priority
    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wd1_irq_flag <= 1'b0;
            wd1_irq_mask <= `DWDT_IC_MASK_RST;
            wd1_irq_priority <= `DWDT_IC_PRIO_RST;
        end
        else
        begin
            if (wr_ic)
            begin
                wd1_irq_mask <= wr_data[`DWDT_IC_MASK_BIT];
                wd1_irq_priority <= wr_data[`DWDT_IC_PRIO_MSB:0];
            end
            // A wrap in the same cycle as a software clear keeps the flag set
            if (wd1_overflow & ~wd1_watchdog_select)
            begin
                wd1_irq_flag <= 1'b1;
            end
            else if (wr_ic)
            begin
                wd1_irq_flag <= wr_data[`DWDT_IC_FLAG_BIT];
            end
        end
    end

    // The request is the flag gated by the mask; its rank comes from the priority field
    assign o_wd1_interval_irq = wd1_irq_flag & ~wd1_irq_mask;
    assign o_wd1_irq_priority = wd1_irq_priority;

    // ---------------- Timer two ----------------

    assign wd2_period_select = watchdog2_mode[4:0];
    // The first mode write reloads the counter so the new period starts from zero
    assign wd2_clear = wr_mode2 & ~wd2_written
        | wr_key & (wr_data == `DWDT_WD2_KEY_CLEAR);
    assign wd2_running = ~wd2_period_select[`DWDT_WD2_STOP_BIT];
    assign wd2_enable = wd2_running
        & (wd2_period_select[`DWDT_WD2_SUB_BIT] ? i_subclock_tick
        : (~i_idle_mode & ~i_stop_mode));

    assign wd2_shift = wd2_period_select[`DWDT_WD2_SUB_BIT]
        ? (`DWDT_WD2_SUB_BASE + {2'h0, wd2_period_select[2:0]})
        : (`DWDT_WD2_MAIN_BASE + {2'h0, wd2_period_select[2:0]});
    assign wd2_limit = (26'h0000001 << wd2_shift) - 26'h0000001;

    dwdt_counter #(
        .WIDTH(`DWDT_WD2_CW)
    ) u_wd2_counter (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clear(wd2_clear),
        .i_enable(wd2_enable),
        .i_limit(wd2_limit),
        // The count stays internal; software only sees what its wrap does
        .o_count(),
        .o_overflow(wd2_overflow)
    );

    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wd2_written <= 1'b0;
            watchdog2_mode <= `DWDT_WD2_MODE_RST;
            watchdog2_refresh_key <= `DWDT_WD2_KEY_RST;
        end
        else
        begin
            // Later writes are dropped, which also keeps a running timer running
            if (wr_mode2 & ~wd2_written)
            begin
                wd2_written <= 1'b1;
                watchdog2_mode <= wr_data[6:0];
            end
            if (wr_key)
            begin
                watchdog2_refresh_key <= wr_data;
            end
        end
    end

    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_wd2_nmi_request <= 1'b0;
            o_wd2_system_reset <= 1'b0;
        end
        else
        begin
            o_wd2_nmi_request <= wd2_overflow
                & ~watchdog2_mode[`DWDT_WD2_ACT_HI_BIT];
            o_wd2_system_reset <= wd2_overflow
                & watchdog2_mode[`DWDT_WD2_ACT_HI_BIT];
        end
    end

    // ---------------- Register read ----------------

    always @*
    begin
        next_readdata = 8'h00;
        if (i_avs_address == `DWDT_OFS_WD1_MODE)
        begin
            next_readdata = {wd1_run_clear_bit, 2'h0, wd1_watchdog_select,
                wd1_overflow_action, 3'h0};
        end
        else if (i_avs_address == `DWDT_OFS_WD1_PERIOD)
        begin
            next_readdata = {5'h00, wd1_period_select};
        end
        else if (i_avs_address == `DWDT_OFS_WD1_IRQ_CTRL)
        begin
            next_readdata = {wd1_irq_flag, wd1_irq_mask, 3'h0, wd1_irq_priority};
        end
        else if (i_avs_address == `DWDT_OFS_WD2_MODE)
        begin
            next_readdata = {1'b0, watchdog2_mode};
        end
        else if (i_avs_address == `DWDT_OFS_WD2_KEY)
        begin
            next_readdata = watchdog2_refresh_key;
        end
        else if (i_avs_address == `DWDT_OFS_STATUS)
        begin
            next_readdata = {4'h0, wd2_running, wd2_written, wd1_lock,
                wd1_run_clear_bit};
        end
    end

    // Read data is latched in the wait cycle and stands when waitrequest drops
    always @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_avs_readdata <= 32'h00000000;
        end
        else if (i_avs_read & ~bus_ack)
        begin
            o_avs_readdata <= {24'h000000, next_readdata};
        end
    end

endmodule

`default_nettype wire

// ### verification/dwdt_top_assertions.sv
// Port-level checks of the dual watchdog block
`timescale 1ns/1ns
`default_nettype none
module dwdt_top_assertions (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_idle_mode,
    input wire logic i_stop_mode,
    input wire logic i_cpu_subclock,
    input wire logic o_wd1_interval_irq,
    input wire logic o_wd1_nmi_request,
    input wire logic o_wd1_system_reset,
    input wire logic o_wd2_nmi_request,
    input wire logic o_wd2_system_reset
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus wait too long");
    first_wait_a: assert property ($rose(i_avs_read) || $rose(i_avs_write)
        |-> o_avs_waitrequest) else $error("no wait on new request");
    idle_nowait_a: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait while idle");
    rdata_upper_a: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    nmi1_pulse_a: assert property (o_wd1_nmi_request |=> !o_wd1_nmi_request [*8])
        else $error("wd1 nmi not a single pulse");
    rst1_pulse_a: assert property (o_wd1_system_reset |=> !o_wd1_system_reset [*8])
        else $error("wd1 reset not a single pulse");
    nmi2_pulse_a: assert property (o_wd2_nmi_request |=> !o_wd2_nmi_request [*8])
        else $error("wd2 nmi not a single pulse");
    rst2_pulse_a: assert property (o_wd2_system_reset |=> !o_wd2_system_reset [*8])
        else $error("wd2 reset not a single pulse");
    wd1_excl_a: assert property (!(o_wd1_nmi_request && o_wd1_system_reset))
        else $error("wd1 nmi and reset together");
    // Two frozen cycles leave no room for an overflow to reach the pins
    wd1_frozen_a: assert property ($past(i_cpu_subclock) && $past(i_cpu_subclock, 2)
        |-> !o_wd1_nmi_request && !o_wd1_system_reset && !$rose(o_wd1_interval_irq))
        else $error("wd1 fired while frozen");
    wd1_standby_a: assert property (($past(i_stop_mode) || $past(i_idle_mode))
        && ($past(i_stop_mode, 2) || $past(i_idle_mode, 2))
        |-> !o_wd1_nmi_request && !o_wd1_system_reset && !$rose(o_wd1_interval_irq))
        else $error("wd1 fired in standby");
    irq_c: cover property ($rose(o_wd1_interval_irq));
    rst1_c: cover property (o_wd1_system_reset);
    nmi2_c: cover property (o_wd2_nmi_request);
    rst2_c: cover property (o_wd2_system_reset);
endmodule
bind dwdt_top dwdt_top_assertions i_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_idle_mode(i_idle_mode),
    .i_stop_mode(i_stop_mode), .i_cpu_subclock(i_cpu_subclock),
    .o_wd1_interval_irq(o_wd1_interval_irq), .o_wd1_nmi_request(o_wd1_nmi_request),
    .o_wd1_system_reset(o_wd1_system_reset), .o_wd2_nmi_request(o_wd2_nmi_request),
    .o_wd2_system_reset(o_wd2_system_reset));
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the dual watchdog block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic i_clock, i_sys_rst, rd_en, wr_en, idle, stp, csub, tick;
    logic [4:0] adr;
    logic [31:0] wdat, rdat;
    wire [31:0] rdata;
    wire wreq, irq, n1, r1, n2, r2;
    wire [2:0] prio;
    int num_errors, check_count, n1n, n1r, n2n, n2r;
    dwdt_top i_dwdt_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(adr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_idle_mode(idle), .i_stop_mode(stp), .i_cpu_subclock(csub),
        .i_subclock_tick(tick), .o_wd1_interval_irq(irq), .o_wd1_irq_priority(prio),
        .o_wd1_nmi_request(n1), .o_wd1_system_reset(r1),
        .o_wd2_nmi_request(n2), .o_wd2_system_reset(r2));
    initial
    begin
        i_clock = 0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        n1n <= i_sys_rst ? 0 : n1n + n1;
        n1r <= i_sys_rst ? 0 : n1r + r1;
        n2n <= i_sys_rst ? 0 : n2n + n2;
        n2r <= i_sys_rst ? 0 : n2r + r2;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clock);
        adr <= a;
        wdat <= {24'h0, d};
        rd_en <= !w;
        wr_en <= w;
        do @(posedge i_clock); while (wreq !== 1'b0);
        rdat = rdata;
        rd_en <= 0;
        wr_en <= 0;
    endtask
    task rst;
        i_sys_rst <= 1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 0;
    endtask
    task t_reset;
        bus(0, 5'h0C, 8'h0); chk(rdat, 32'h67);
        bus(0, 5'h10, 8'h0); chk(rdat, 32'h9A);
        bus(0, 5'h08, 8'h0); chk(rdat, 32'h47);
        bus(0, 5'h14, 8'h0); chk(rdat, 32'h08);
        bus(0, 5'h18, 8'h0); chk(rdat, 32'h0);
        chk(prio, 3'h7);
    endtask
    // Subclock source keeps counting through stop mode; bit 6 picks the action
    task t_wd2(input logic [7:0] mode);
        stp <= 1;
        bus(1, 5'h0C, mode);
        bus(1, 5'h0C, 8'h1F);
        bus(0, 5'h0C, 8'h0); chk(rdat, {24'h0, mode});
        repeat (400) @(posedge i_clock);
        bus(1, 5'h10, 8'hAC);
        bus(0, 5'h10, 8'h0); chk(rdat, 32'hAC);
        repeat (400) @(posedge i_clock);
        chk(n2n + n2r, 0);
        repeat (200) @(posedge i_clock);
        chk(n2n, mode[6] ? 0 : 1);
        chk(n2r, mode[6] ? 1 : 0);
        chk(n1n + n1r, 0);
        stp <= 0;
    endtask
    // A first mode write of the stop setting leaves timer two halted
    task t_wd2_off;
        bus(1, 5'h0C, 8'h1F);
        bus(0, 5'h14, 8'h0); chk(rdat, 32'h04);
    endtask
    task t_wd1_int;
        bus(1, 5'h08, 8'h07);
        bus(1, 5'h04, 8'h00);
        bus(1, 5'h00, 8'h80);
        repeat (4000) @(posedge i_clock);
        bus(1, 5'h00, 8'h80);
        idle <= 1;
        repeat (500) @(posedge i_clock);
        idle <= 0;
        // Let the count move so that the freeze below has a value to hold
        repeat (1000) @(posedge i_clock);
        csub <= 1;
        repeat (500) @(posedge i_clock);
        csub <= 0;
        repeat (7000) @(posedge i_clock);
        chk(irq, 0);
        repeat (300) @(posedge i_clock);
        chk(irq, 1);
        bus(1, 5'h08, 8'hC7);
        bus(0, 5'h08, 8'h0); chk(rdat, 32'hC7);
        chk(irq, 0);
        bus(1, 5'h08, 8'h07);
    endtask
    task t_wd1_wdt(input logic [7:0] mode);
        bus(1, 5'h00, mode);
        bus(1, 5'h00, 8'h00);
        bus(1, 5'h00, 8'h80);
        bus(0, 5'h14, 8'h0); chk(rdat[1:0], 2'h3);
        repeat (8100) @(posedge i_clock);
        chk(n1n + n1r, 0);
        repeat (300) @(posedge i_clock);
        chk({n1n[1:0], n1r[1:0]}, mode[3] ? 4'h1 : 4'h4);
    endtask
    initial
    begin
        i_sys_rst = 1;
        {rd_en, wr_en, idle, stp, csub} = 0;
        tick = 1;
        adr = 0;
        wdat = 0;
        rst;
        t_reset;
        t_wd2(8'h08);
        t_wd1_int;
        t_wd1_wdt(8'h98);
        rst;
        t_wd2(8'h48);
        t_wd1_wdt(8'h90);
        rst;
        t_wd2_off;
        give_verdict;
    end
    initial
    begin
        #(20 * 60000);
        num_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
